// ===== sched_pkg.sv
/*
 * Shared constants and types for the scan scheduler.
 * Assumes a single 50 MHz clock and a synchronous active-high reset.
 */
// How it works
// - Timer task raised every 5 to 1000 ms, configured in 5 ms steps.
// - Timer task preempts main or lower processing and runs at top priority.
// - Counter preset match starts I/O task one at once, preempting main or lower processing.
// - Selected edge of interrupt input starts I/O task three at once.
// - Requests arriving during any interrupt task wait until it finishes.
// - Simultaneous requests served timer, then I/O one, two, three, four.
// - Interrupt task ends at its return-from-interrupt; suspended work resumes.
// - Main program runs exactly once per scan.
// - Main program stops at its end marker; later instructions never run.
// - Initial sub-program runs once, first scan only, before the main program.
// - Eight program types: main, initial, timer, four I/O, subroutines.
// - Subroutine numbers 0..15 basic, 0..255 extended.
// - Calls carry a target number; subroutine return carries none.
// - Extended nests subroutines up to 3 levels; basic allows no nesting.
// - Extended has 8 k and 4 k modes; only 4 k allows on-line edits.
// - Basic variant has fixed 2 k step capacity, no mode choice.
// - Memory clear puts combined four-word I/O type in allocation slot 0.
// - Uncommitted system information is replaced by stored copy at initial load.
// - Block numbers only separate code and never change execution order.
// - I/O registers share one numbering; each number is input or output.
package sched_pkg;
    // ****************
    // Timing
    // ****************
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int INTERVAL_STEP_MS = 5;
    localparam int INTERVAL_MAX_MS = 1000;
    localparam logic [7:0] INTERVAL_MAX_STEPS = 8'(INTERVAL_MAX_MS / INTERVAL_STEP_MS);
    localparam logic [7:0] INTERVAL_MIN_STEPS = 8'h01;

    // ****************
    // Subroutines and capacity
    // ****************
    localparam logic [7:0] SUB_MAX_BASIC = 8'h0f;
    localparam logic [7:0] SUB_MAX_EXT = 8'hff;
    localparam logic [1:0] NEST_BASIC = 2'h1;
    localparam logic [1:0] NEST_EXT = 2'h3;
    localparam logic [13:0] CAP_BASIC = 14'h0800;
    localparam logic [13:0] CAP_EXT_4K = 14'h1000;
    localparam logic [13:0] CAP_EXT_8K = 14'h2000;

    // ****************
    // Reset values and codes
    // ****************
    localparam logic [7:0] IO_TYPE_NONE = 8'h00;
    localparam logic [7:0] IO_TYPE_FOUR_WORD = 8'h44;
    localparam logic [15:0] SCAN_COUNT_RESET = 16'h0000;
    localparam logic [15:0] SYSINFO_RESET = 16'h0000;

    typedef enum logic [3:0] {
        TASK_IDLE = 4'h0,
        TASK_MAIN = 4'h1,
        TASK_INIT = 4'h2,
        TASK_TIMER = 4'h3,
        TASK_IO1 = 4'h4,
        TASK_IO2 = 4'h5,
        TASK_IO3 = 4'h6,
        TASK_IO4 = 4'h7,
        TASK_SUB = 4'h8
    } task_t;

    typedef enum logic [1:0] {
        SCAN_HOUSE = 2'b00,
        SCAN_INIT = 2'b01,
        SCAN_MAIN = 2'b10
    } scan_t;
endpackage

// ===== interval_timer.sv
/*
 * Cyclic timer that pulses when the configured interval has elapsed.
 * Assumes interval_steps is stable logic on clk_sys.
 */
`timescale 1ns/10ps
module interval_timer #(
    parameter int MS_CYCLES = sched_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] interval_steps,
    output logic due
);
    localparam int CW = $clog2(MS_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cyc;
        logic [9:0] ms;
        logic due;
    } tmr_t;

    tmr_t st_q, st_d;
    logic [7:0] steps;
    logic [9:0] limit_ms;

    // ****************
    // Interval count
    // ****************
    always_comb begin
        steps = interval_steps;
        // Out-of-range settings clamp rather than stall the timer
        if (steps < sched_pkg::INTERVAL_MIN_STEPS) begin
            steps = sched_pkg::INTERVAL_MIN_STEPS;
        end else if (steps > sched_pkg::INTERVAL_MAX_STEPS) begin
            steps = sched_pkg::INTERVAL_MAX_STEPS;
        end
        limit_ms = 10'(steps * sched_pkg::INTERVAL_STEP_MS);
        st_d = st_q;
        st_d.due = 1'b0;
        if (st_q.cyc == CW'(MS_CYCLES - 1)) begin
            st_d.cyc = '0;
            if (st_q.ms >= limit_ms - 10'h001) begin
                st_d.ms = 10'h000;
                st_d.due = 1'b1;
            end else begin
                st_d.ms = st_q.ms + 10'h001;
            end
        end else begin
            st_d.cyc = st_q.cyc + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign due = st_q.due;
endmodule // interval_timer

// ===== pending_flags.sv
/*
 * Sticky pending flags, one per interrupt source.
 * Assumes set and clear come from logic on clk_sys.
 */
`timescale 1ns/10ps
module pending_flags #(
    parameter int N = 5
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] pend
);
    typedef struct packed {
        logic [N-1:0] pend;
    } pnd_t;

    pnd_t st_q, st_d;

    always_comb begin
        // Set wins so a request landing on its own dispatch is kept
        st_d.pend = (st_q.pend & ~clr) | set;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pend = st_q.pend;
endmodule // pending_flags

// ===== scan_scheduler.sv
/*
 * Scan and interrupt task scheduler of a small controller.
 * Assumes the program executor reports end, return and call events as
 * one-cycle pulses on clk_sys; interrupt input pins are asynchronous.
 */
`timescale 1ns/10ps
module scan_scheduler #(
    parameter int MS_CYCLES = sched_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ext_variant,
    input wire logic mem_4k_mode,
    input wire logic init_present,
    input wire logic [7:0] interval_steps,
    input wire logic counter_match1,
    input wire logic counter_match2,
    input wire logic irq_in3,
    input wire logic irq_in4,
    input wire logic edge_fall3,
    input wire logic edge_fall4,
    input wire logic end_of_program,
    input wire logic return_from_interrupt,
    input wire logic call_valid,
    input wire logic [7:0] call_number,
    input wire logic subroutine_return,
    input wire logic memory_clear,
    input wire logic [15:0] nv_sysinfo,
    input wire logic [7:0] io_reg_number,
    input wire logic [7:0] io_input_words,
    output sched_pkg::task_t run_task_q,
    output logic int_active_q,
    output logic dispatch_q,
    output logic [15:0] scan_count_q,
    output logic first_scan_q,
    output logic [1:0] sub_depth_q,
    output logic [7:0] sub_number_q,
    output logic call_error_q,
    output logic [13:0] capacity_steps_q,
    output logic online_edit_ok_q,
    output logic [7:0] io_slot0_type_q,
    output logic [15:0] sysinfo_q,
    output logic io_reg_is_input_q
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        sched_pkg::scan_t scan;
        logic first;
        logic loaded;
        logic int_active;
        sched_pkg::task_t int_task;
        logic [1:0][1:0] depth;
        logic [1:0][2:0][7:0] stack;
        sched_pkg::task_t run_task;
        logic dispatch;
        logic [15:0] scan_count;
        logic [1:0] sub_depth;
        logic [7:0] sub_number;
        logic call_error;
        logic [13:0] capacity;
        logic online_ok;
        logic [7:0] slot0;
        logic [15:0] sysinfo;
        logic reg_in;
    } sch_t;

    sch_t st_q, st_d;
    logic timer_due;
    logic [4:0] req, pend, clr;

    // ****************
    // Decoding helpers
    // ****************
    function automatic logic [2:0] first_set(input logic [4:0] p);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (p[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic sched_pkg::task_t src_task(input logic [2:0] i);
        sched_pkg::task_t t;
        unique case (i)
            3'h0: t = sched_pkg::TASK_TIMER;
            3'h1: t = sched_pkg::TASK_IO1;
            3'h2: t = sched_pkg::TASK_IO2;
            3'h3: t = sched_pkg::TASK_IO3;
            default: t = sched_pkg::TASK_IO4;
        endcase
        return t;
    endfunction

    interval_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .interval_steps(interval_steps),
        .due(timer_due)
    );

    pending_flags #(
        .N(5)
    ) u_pending (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(req),
        .clr(clr),
        .pend(pend)
    );

    // ****************
    // Next state
    // ****************
    always_comb begin
        logic ctx;
        logic [1:0] lim;
        logic [7:0] max_num;
        logic [2:0] pick;
        logic e3;
        logic e4;
        ctx = st_q.int_active;
        lim = ext_variant ? sched_pkg::NEST_EXT : sched_pkg::NEST_BASIC;
        max_num = ext_variant ? sched_pkg::SUB_MAX_EXT : sched_pkg::SUB_MAX_BASIC;
        pick = first_set(pend);
        e3 = edge_fall3 ? (!st_q.s2[0] && st_q.s3[0]) : (st_q.s2[0] && !st_q.s3[0]);
        e4 = edge_fall4 ? (!st_q.s2[1] && st_q.s3[1]) : (st_q.s2[1] && !st_q.s3[1]);
        st_d = st_q;
        clr = 5'h00;
        st_d.dispatch = 1'b0;
        st_d.call_error = 1'b0;

        // Two sync flops before the edge detector
        st_d.s1 = {irq_in4, irq_in3};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        req = {e4, e3, counter_match2, counter_match1, timer_due};

        // Interrupt dispatch; waits while another interrupt runs
        if (st_q.int_active) begin
            if (return_from_interrupt) begin
                st_d.int_active = 1'b0;
                st_d.depth[1] = 2'h0;
            end
        end else if (pend != 5'h00) begin
            st_d.int_active = 1'b1;
            st_d.int_task = src_task(pick);
            st_d.dispatch = 1'b1;
            clr[pick] = 1'b1;
        end

        // Scan sequence waits while an interrupt runs
        if (!st_q.int_active) begin
            unique case (st_q.scan)
                sched_pkg::SCAN_HOUSE: begin
                    if (st_q.first && init_present) begin
                        st_d.scan = sched_pkg::SCAN_INIT;
                    end else begin
                        st_d.scan = sched_pkg::SCAN_MAIN;
                        st_d.first = 1'b0;
                    end
                end
                sched_pkg::SCAN_INIT: begin
                    if (end_of_program) begin
                        st_d.scan = sched_pkg::SCAN_MAIN;
                        st_d.first = 1'b0;
                        st_d.depth[0] = 2'h0;
                    end
                end
                sched_pkg::SCAN_MAIN: begin
                    // Order follows the executor only; block markers are ignored
                    if (end_of_program) begin
                        st_d.scan = sched_pkg::SCAN_HOUSE;
                        st_d.scan_count = st_q.scan_count + 16'h0001;
                        st_d.depth[0] = 2'h0;
                    end
                end
                default: begin
                    st_d.scan = sched_pkg::SCAN_HOUSE;
                end
            endcase
        end

        // Nesting per context; interrupts keep their own stack
        if (call_valid) begin
            if (st_q.depth[ctx] < lim && call_number <= max_num) begin
                st_d.stack[ctx][st_q.depth[ctx]] = call_number;
                st_d.depth[ctx] = st_q.depth[ctx] + 2'h1;
            end else begin
                st_d.call_error = 1'b1;
            end
        end else if (subroutine_return && st_q.depth[ctx] != 2'h0) begin
            st_d.depth[ctx] = st_q.depth[ctx] - 2'h1;
        end

        st_d.sub_depth = st_d.depth[st_d.int_active];
        st_d.sub_number = (st_d.sub_depth == 2'h0) ? 8'h00
            : st_d.stack[st_d.int_active][st_d.sub_depth - 2'h1];
        if (st_d.int_active) begin
            st_d.run_task = st_d.int_task;
        end else if (st_d.sub_depth != 2'h0) begin
            st_d.run_task = sched_pkg::TASK_SUB;
        end else if (st_d.scan == sched_pkg::SCAN_MAIN) begin
            st_d.run_task = sched_pkg::TASK_MAIN;
        end else if (st_d.scan == sched_pkg::SCAN_INIT) begin
            st_d.run_task = sched_pkg::TASK_INIT;
        end else begin
            st_d.run_task = sched_pkg::TASK_IDLE;
        end

        // Memory mode limits
        st_d.capacity = !ext_variant ? sched_pkg::CAP_BASIC
            : (mem_4k_mode ? sched_pkg::CAP_EXT_4K : sched_pkg::CAP_EXT_8K);
        st_d.online_ok = ext_variant && mem_4k_mode;

        // Shared numbering: low numbers are inputs, the rest outputs
        st_d.reg_in = io_reg_number < io_input_words;

        // Stored copy wins at load
        if (!st_q.loaded) begin
            st_d.sysinfo = nv_sysinfo;
            st_d.loaded = 1'b1;
        end
        if (memory_clear) begin
            st_d.slot0 = sched_pkg::IO_TYPE_FOUR_WORD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= '0;
            st_q.scan <= sched_pkg::SCAN_HOUSE;
            st_q.first <= 1'b1;
            st_q.int_task <= sched_pkg::TASK_IDLE;
            st_q.run_task <= sched_pkg::TASK_IDLE;
            st_q.scan_count <= sched_pkg::SCAN_COUNT_RESET;
            st_q.slot0 <= sched_pkg::IO_TYPE_NONE;
            st_q.sysinfo <= sched_pkg::SYSINFO_RESET;
            st_q.capacity <= sched_pkg::CAP_BASIC;
        end else begin
            st_q <= st_d;
        end
    end

    assign run_task_q = st_q.run_task;
    assign int_active_q = st_q.int_active;
    assign dispatch_q = st_q.dispatch;
    assign scan_count_q = st_q.scan_count;
    assign first_scan_q = st_q.first;
    assign sub_depth_q = st_q.sub_depth;
    assign sub_number_q = st_q.sub_number;
    assign call_error_q = st_q.call_error;
    assign capacity_steps_q = st_q.capacity;
    assign online_edit_ok_q = st_q.online_ok;
    assign io_slot0_type_q = st_q.slot0;
    assign sysinfo_q = st_q.sysinfo;
    assign io_reg_is_input_q = st_q.reg_in;

    // ****************
    // Checks
    // ****************
    timer_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!st_q.int_active && pend[0]) |=> (st_q.int_active && st_q.int_task == sched_pkg::TASK_TIMER))
        else $error("timer request not served first");

    hold_pending_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.int_active && !return_from_interrupt) |=> (st_q.int_active && !st_q.dispatch))
        else $error("interrupt dispatched over a running task");

    int_return_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.int_active && return_from_interrupt) |=> !st_q.int_active)
        else $error("interrupt task did not end on return");

    match_start_a: assert property (@(posedge clk_sys) disable iff (rst)
        (counter_match1 && !timer_due && !st_q.int_active && pend == 5'h00) |=> ##1
        (st_q.int_active && st_q.int_task == sched_pkg::TASK_IO1))
        else $error("counter match did not start task one");

    edge_req_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.s2[0] && !st_q.s3[0] && !edge_fall3) |=> pend[3])
        else $error("input edge not captured");

    main_once_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.scan == sched_pkg::SCAN_MAIN && end_of_program && !st_q.int_active) |=>
        (st_q.scan == sched_pkg::SCAN_HOUSE && st_q.scan_count == $past(st_q.scan_count) + 16'h0001))
        else $error("scan did not close at end marker");

    init_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q.scan == sched_pkg::SCAN_INIT) |-> (st_q.first && st_q.scan_count == 16'h0000))
        else $error("initial program outside first scan");

    nest_basic_a: assert property (@(posedge clk_sys) disable iff (rst)
        (call_valid && !ext_variant && st_q.depth[st_q.int_active] != 2'h0) |=> call_error_q)
        else $error("basic variant allowed nesting");

    sub_range_a: assert property (@(posedge clk_sys) disable iff (rst)
        (call_valid && !ext_variant && call_number > 8'h0f) |=> call_error_q)
        else $error("subroutine number out of range accepted");

    slot_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        memory_clear |=> (io_slot0_type_q == sched_pkg::IO_TYPE_FOUR_WORD))
        else $error("slot 0 not set on memory clear");

    timer_run_c: cover property (@(posedge clk_sys) disable iff (rst)
        st_q.dispatch && st_q.int_task == sched_pkg::TASK_TIMER);
    io4_run_c: cover property (@(posedge clk_sys) disable iff (rst)
        st_q.dispatch && st_q.int_task == sched_pkg::TASK_IO4);
    deep_nest_c: cover property (@(posedge clk_sys) disable iff (rst)
        st_q.sub_depth == 2'h3);
endmodule // scan_scheduler

// ===== prog_model.sv
/*
 * Behavioural user program executor facing the scan scheduler.
 * Assumes run_task_q and int_active_q are registered on clk_sys.
 */
`timescale 1ns/10ps
module prog_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire sched_pkg::task_t run_task_q,
    input wire logic int_active_q,
    input wire logic [7:0] run_len,
    output logic end_of_program,
    output logic return_from_interrupt
);
    // ****************
    // Task length
    // ****************
    sched_pkg::task_t last_q;
    logic [7:0] cnt_q;
    logic base_run;
    // Calls stretch a main or initial caller; an interrupt task keeps counting
    assign base_run = !int_active_q && (run_task_q == sched_pkg::TASK_MAIN || run_task_q == sched_pkg::TASK_INIT);
    initial begin
        end_of_program = 1'b0;
        return_from_interrupt = 1'b0;
        cnt_q = 8'h00;
        last_q = sched_pkg::TASK_IDLE;
    end
    always @(negedge clk_sys) begin
        end_of_program <= 1'b0;
        return_from_interrupt <= 1'b0;
        last_q <= run_task_q;
        if (rst || run_task_q != last_q) begin
            cnt_q <= 8'h00;
        end else if (base_run || int_active_q) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == run_len) begin
                end_of_program <= base_run;
                return_from_interrupt <= int_active_q;
            end
        end
    end
endmodule // prog_model

// ===== testbench.sv
/*
 * Self-checking bench for the scan scheduler.
 * Assumes sched_pkg is compiled first; inputs change on the falling edge.
 */
`timescale 1ns/10ps
module testbench;
    localparam int MSC = 10;
    logic clk_sys, rst, ext_variant, mem_4k_mode, init_present, counter_match1, counter_match2;
    logic irq_in3, irq_in4, edge_fall3, edge_fall4, call_valid, subroutine_return, memory_clear;
    logic end_of_program, return_from_interrupt, int_active_q, dispatch_q, first_scan_q, call_error_q;
    logic online_edit_ok_q, io_reg_is_input_q;
    logic [7:0] interval_steps, call_number, io_reg_number, io_input_words, run_len, rnd;
    logic [7:0] sub_number_q, io_slot0_type_q, steps_tab [3];
    logic [15:0] nv_sysinfo, scan_count_q, sysinfo_q, sc;
    logic [1:0] sub_depth_q;
    logic [13:0] capacity_steps_q;
    sched_pkg::task_t run_task_q, prev_t;
    sched_pkg::task_t log_q [$];
    sched_pkg::task_t ord [5];
    int num_errors, comparisons, cyc, t_last, gap, init_n, n0, k;

    scan_scheduler #(.MS_CYCLES(MSC)) i_scan_scheduler (.clk_sys, .rst, .ext_variant, .mem_4k_mode,
        .init_present, .interval_steps, .counter_match1, .counter_match2, .irq_in3, .irq_in4, .edge_fall3,
        .edge_fall4, .end_of_program, .return_from_interrupt, .call_valid, .call_number, .subroutine_return,
        .memory_clear, .nv_sysinfo, .io_reg_number, .io_input_words, .run_task_q, .int_active_q, .dispatch_q,
        .scan_count_q, .first_scan_q, .sub_depth_q, .sub_number_q, .call_error_q, .capacity_steps_q,
        .online_edit_ok_q, .io_slot0_type_q, .sysinfo_q, .io_reg_is_input_q);
    prog_model i_prog_model (.clk_sys, .rst, .run_task_q, .int_active_q, .run_len, .end_of_program,
        .return_from_interrupt);

    // ****************
    // Helpers
    // ****************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [15:0] period_exp(input logic [7:0] s);
        return 16'((s == 8'h00) ? 1 : ((s > 8'd200) ? 200 : int'(s))) * 16'd5 * 16'(MSC);
    endfunction
    function automatic logic [13:0] cap_exp(input logic e, input logic m);
        return !e ? 14'h0800 : (m ? 14'h1000 : 14'h2000);
    endfunction
    task automatic close_out;
        if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_task(input sched_pkg::task_t t, input logic eq, input int lim);
        int n;
        n = 0;
        while (((run_task_q === t) != eq) && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= lim) begin
            check("wait_task", 16'h0, 16'h1);
            close_out();
        end
    endtask
    task automatic wait_log(input int cnt, input int lim);
        int n;
        n = 0;
        while (log_q.size() < cnt && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= lim) begin
            check("wait_log", 16'h0, 16'h1);
            close_out();
        end
    endtask
    task automatic fresh_main;
        wait_task(sched_pkg::TASK_MAIN, 1'b0, 400);
        wait_task(sched_pkg::TASK_MAIN, 1'b1, 400);
    endtask
    task automatic pulse_wait;
        @(negedge clk_sys);
        call_valid = 1'b0;
        subroutine_return = 1'b0;
    endtask
    task automatic do_call(input logic [7:0] num, input logic ok, input logic [1:0] d);
        call_valid = 1'b1;
        call_number = num;
        pulse_wait();
        check("call_error", call_error_q, !ok);
        check("sub_depth", sub_depth_q, d);
        if (ok) check("sub_number", sub_number_q, num);
        @(negedge clk_sys);
    endtask
    task automatic do_return(input logic [1:0] d);
        subroutine_return = 1'b1;
        pulse_wait();
        check("return_depth", sub_depth_q, d);
        @(negedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;
    // Falling edge, away from register updates
    always @(negedge clk_sys) begin
        if (dispatch_q === 1'b1) begin
            log_q.push_back(run_task_q);
            gap = cyc - t_last;
            t_last = cyc;
        end
        if (run_task_q === sched_pkg::TASK_INIT && prev_t !== sched_pkg::TASK_INIT) init_n++;
        prev_t = run_task_q;
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        {rst, init_present} = 2'b11;
        {ext_variant, mem_4k_mode, counter_match1, counter_match2, irq_in3, irq_in4} = 6'h00;
        {edge_fall3, edge_fall4, call_valid, subroutine_return, memory_clear} = 5'h00;
        {call_number, io_reg_number, io_input_words} = 24'h000000;
        {num_errors, comparisons, cyc, t_last, gap, init_n} = {6{32'h0}};
        interval_steps = 8'd200;
        run_len = 8'h06;
        rnd = 8'h51;
        nv_sysinfo = 16'h5a3c;
        steps_tab = '{8'h00, 8'h01, 8'h03};
        ord = '{sched_pkg::TASK_IO1, sched_pkg::TASK_IO1, sched_pkg::TASK_IO2, sched_pkg::TASK_IO3,
            sched_pkg::TASK_IO4};
        repeat (4) @(negedge clk_sys);
        check("rst_task", run_task_q, sched_pkg::TASK_IDLE);
        check("rst_cap", capacity_steps_q, 14'h0800);
        check("rst_slot0", io_slot0_type_q, 8'h00);
        rst = 1'b0;
        wait_task(sched_pkg::TASK_INIT, 1'b1, 20);
        check("sysinfo", sysinfo_q, nv_sysinfo);
        wait_task(sched_pkg::TASK_MAIN, 1'b1, 40);
        @(negedge clk_sys);
        check("first_scan", first_scan_q, 1'b0);
        sc = scan_count_q;
        for (k = 0; k < 3; k++) begin
            wait_task(sched_pkg::TASK_MAIN, 1'b0, 40);
            @(negedge clk_sys);
            check("house_len", run_task_q, sched_pkg::TASK_MAIN);
        end
        check("scan_count", scan_count_q, sc + 16'd3);
        for (k = 0; k < 4; k++) begin
            {ext_variant, mem_4k_mode} = 2'(k);
            repeat (3) @(negedge clk_sys);
            check("capacity", capacity_steps_q, cap_exp(ext_variant, mem_4k_mode));
            check("online_edit", online_edit_ok_q, ext_variant & mem_4k_mode);
        end
        ext_variant = 1'b0;
        memory_clear = 1'b1;
        @(negedge clk_sys);
        memory_clear = 1'b0;
        @(negedge clk_sys);
        check("slot0", io_slot0_type_q, sched_pkg::IO_TYPE_FOUR_WORD);
        for (k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            io_reg_number = rnd;
            rnd = lfsr(rnd);
            io_input_words = (k == 0) ? io_reg_number : rnd;
            @(negedge clk_sys);
            check("io_is_input", io_reg_is_input_q, io_reg_number < io_input_words);
        end
        run_len = 8'd60;
        fresh_main();
        counter_match1 = 1'b1;
        @(negedge clk_sys);
        counter_match1 = 1'b0;
        @(negedge clk_sys);
        check("io1_active", int_active_q, 1'b1);
        check("io1_task", run_task_q, sched_pkg::TASK_IO1);
        wait_task(sched_pkg::TASK_IO1, 1'b0, 100);
        check("resume", run_task_q, sched_pkg::TASK_MAIN);
        // More pulses land while IO1 runs
        run_len = 8'd30;
        fresh_main();
        n0 = log_q.size();
        counter_match1 = 1'b1;
        @(negedge clk_sys);
        {counter_match1, counter_match2, irq_in3, irq_in4} = 4'h7;
        @(negedge clk_sys);
        counter_match2 = 1'b0;
        @(negedge clk_sys);
        {counter_match1, counter_match2} = 2'b11;
        @(negedge clk_sys);
        {counter_match1, counter_match2} = 2'b00;
        repeat (8) @(negedge clk_sys);
        check("held", 16'(log_q.size() - n0), 16'd1);
        wait_log(n0 + 5, 400);
        for (k = 0; k < 5; k++) check("order", log_q[n0 + k], ord[k]);
        {irq_in3, irq_in4} = 2'b00;
        repeat (60) @(negedge clk_sys);
        check("once_each", 16'(log_q.size() - n0), 16'd5);
        {edge_fall3, edge_fall4} = 2'b11;
        repeat (40) @(negedge clk_sys);
        for (k = 0; k < 2; k++) begin
            n0 = log_q.size();
            {irq_in4, irq_in3} = 2'(k + 1);
            repeat (40) @(negedge clk_sys);
            check("rise_ignored", 16'(log_q.size() - n0), 16'd0);
            {irq_in3, irq_in4} = 2'b00;
            wait_log(n0 + 1, 20);
            check("fall_task", log_q[n0], (k == 1) ? sched_pkg::TASK_IO4 : sched_pkg::TASK_IO3);
            repeat (40) @(negedge clk_sys);
        end
        run_len = 8'd200;
        fresh_main();
        rnd = lfsr(rnd);
        do_call(8'h0f, 1'b1, 2'd1);
        do_call(8'h03, 1'b0, 2'd1);
        do_return(2'd0);
        do_call(8'h10, 1'b0, 2'd0);
        do_call({4'h0, rnd[3:0]}, 1'b1, 2'd1);
        do_return(2'd0);
        ext_variant = 1'b1;
        do_call(8'hff, 1'b1, 2'd1);
        do_call(rnd, 1'b1, 2'd2);
        do_call(8'h07, 1'b1, 2'd3);
        do_call(8'h09, 1'b0, 2'd3);
        for (k = 3; k >= 0; k--) do_return(2'((k > 0) ? k - 1 : 0));
        run_len = 8'h03;
        for (k = 0; k < 3; k++) begin
            interval_steps = steps_tab[k];
            n0 = log_q.size();
            wait_log(n0 + 3, 12000);
            check("timer_task", log_q[n0 + 2], sched_pkg::TASK_TIMER);
            check("timer_gap", 16'(gap), period_exp(steps_tab[k]));
        end
        check("init_once", 16'(init_n), 16'd1);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("rerst_count", scan_count_q, 16'h0000);
        check("rerst_slot0", io_slot0_type_q, 8'h00);
        close_out();
    end
endmodule // testbench
